// ==== rtl/istrc_pkg.sv ====
// constants, field layouts and carrier types of the sample timing and rate control block
package istrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned INT_SAMPLE_HZ    = 2000;
    localparam int unsigned INT_TICK_CYCLES  = CLK_HZ / INT_SAMPLE_HZ;
    localparam int unsigned DV_PULSE_NS      = 1000;
    localparam int unsigned DV_PULSE_CYCLES  = DV_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned SYNC_PULSE_NS    = 1000;
    localparam int unsigned SYNC_PULSE_CYCLES = SYNC_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W           = 24;
    localparam int unsigned PULSE_W          = 8;
    localparam int unsigned PERIOD_W         = 26;
    localparam int unsigned ACC_W            = 27;

    ////////////////////////////////////////////////////////////////////////////
    // serial frames and byte addresses
    localparam logic [4:0] FRAME_BITS  = 5'h10;
    localparam logic [6:0] ADDR_CTRL_LO = 7'h60;
    localparam logic [6:0] ADDR_CTRL_HI = 7'h61;
    localparam logic [6:0] ADDR_UPS_LO  = 7'h62;
    localparam logic [6:0] ADDR_UPS_HI  = 7'h63;
    localparam logic [6:0] ADDR_DEC_LO  = 7'h64;
    localparam logic [6:0] ADDR_DEC_HI  = 7'h65;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and masks
    localparam logic [15:0] CTRL_RESET    = 16'h00C1;
    localparam logic [15:0] CTRL_WMASK    = 16'h03DF;
    localparam logic [15:0] UPSCALE_RESET = 16'h07D0;
    localparam logic [15:0] DEC_RESET     = 16'h0000;
    localparam logic [10:0] DEC_MAX       = 11'h7CF;

    ////////////////////////////////////////////////////////////////////////////
    // timing modes
    localparam logic [1:0] SYNC_INTERNAL = 2'h0;
    localparam logic [1:0] SYNC_DIRECT   = 2'h1;
    localparam logic [1:0] SYNC_SCALED   = 2'h2;
    localparam logic [1:0] SYNC_OUTPUT   = 2'h3;

    typedef struct packed {
        logic [5:0] unused;
        logic       burst_word_width_select;
        logic       burst_delta_select;
        logic       gyro_lin_comp;
        logic       accel_corner_align;
        logic       spare;
        logic       sensor_bandwidth_select;
        logic [1:0] sync_mode;
        logic       sync_rising;
        logic       dv_active_high;
    } istrc_ctrl_t;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } istrc_frame_t;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } istrc_ser_state_t;

endpackage

// ==== rtl/istrc_top.sv ====
// sample timing, output rate and control word of the inertial sensor
`timescale 1ns/100ps
// What this block does
// - bit 9 selects 32 or 16-bit burst words
// - bit 8 selects delta or raw burst content
// - bit 7 enables gyro linear-acceleration compensation
// - bit 6 enables accelerometer corner alignment
// - bit 4 limits sensor bandwidth to 370 Hz
// - mode 00 samples from internal 2 kHz
// - mode 01 samples on timing pin edges
// - mode 10 multiplies slow timing pin clock
// - mode 11 internal clock, pin marks samples
// - bit 1 picks timing pin active edge
// - bit 0 set gives active-high data valid
// - default enables alignment and gyro compensation
// - multiplier register resets to 0x07D0
// - decimation uses bits 10:0, max 1999
// - decimation extends interval per output update
// - internal rate is 2000 over decimation+1
// - scaled rate is fsync times multiplier over decimation+1
// - direct mode uses multiplier of one
// - control word at 0x60, reset 0x00C1
module istrc_top #(
    parameter int unsigned INT_TICK_CYCLES = istrc_pkg::INT_TICK_CYCLES
) (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_B,
    // serial port, mode 3
    input  wire logic SCLK,
    input  wire logic CS_B,
    input  wire logic DIN,
    output logic      DOUT,
    // timing pin
    input  wire logic SYNC_I,
    output logic      SYNC_O,
    output logic      SYNC_OE,
    // data valid pin
    output logic      DATA_VALID_PIN,
    // towards the sensor datapath
    output logic      SAMPLE_TICK,
    output logic      OUTPUT_UPDATE,
    output logic      BURST_WORD_WIDTH_SELECT,
    output logic      BURST_DELTA_SELECT,
    output logic      GYRO_LIN_COMP,
    output logic      ACCEL_CORNER_ALIGN,
    output logic      SENSOR_BANDWIDTH_SELECT
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] din_sync;
    logic [2:0] sync_sync;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sclk_sync <= 3'h7;
            cs_sync   <= 3'h7;
            din_sync  <= 2'h0;
            sync_sync <= 3'h0;
        end
        else
        begin
            sclk_sync <= {sclk_sync[1:0], SCLK};
            cs_sync   <= {cs_sync[1:0], CS_B};
            din_sync  <= {din_sync[0], DIN};
            sync_sync <= {sync_sync[1:0], SYNC_I};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign cs_fall   = ~cs_sync[1] & cs_sync[2];
    assign cs_rise   = cs_sync[1] & ~cs_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    // serial frame receiver
    istrc_pkg::istrc_ser_state_t ser_state;
    istrc_pkg::istrc_frame_t     frame;
    logic [4:0]                  bit_cnt;
    logic                        frame_done;
    logic [15:0]                 tx_shift;
    logic [6:0]                  rd_addr;
    logic [15:0]                 read_word;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ser_state  <= istrc_pkg::SER_IDLE;
            frame      <= '0;
            bit_cnt    <= '0;
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= 1'b0;
            unique case (ser_state)
                istrc_pkg::SER_IDLE:
                begin
                    bit_cnt <= '0;
                    if (cs_fall)
                        ser_state <= istrc_pkg::SER_SHIFT;
                end
                istrc_pkg::SER_SHIFT:
                begin
                    if (cs_rise)
                    begin
                        ser_state <= istrc_pkg::SER_IDLE;
                        // short frames are dropped whole; long frames keep their first 16 bits
                        frame_done <= (bit_cnt == istrc_pkg::FRAME_BITS);
                    end
                    else if (sclk_rise && bit_cnt != istrc_pkg::FRAME_BITS)
                    begin
                        frame   <= {frame[14:0], din_sync[1]};
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    logic wr_en;
    assign wr_en = frame_done & frame.write;

    // a read frame names the word returned in the next frame
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            rd_addr <= istrc_pkg::ADDR_CTRL_LO;
        else if (frame_done && !frame.write)
            rd_addr <= frame.addr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    istrc_pkg::istrc_ctrl_t misc_control_word;
    logic [15:0]            external_clock_multiplier;
    logic [15:0]            output_decimation_rate;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            misc_control_word <= istrc_pkg::CTRL_RESET;
        else if (wr_en && frame.addr == istrc_pkg::ADDR_CTRL_LO)
            misc_control_word[7:0] <= frame.data & istrc_pkg::CTRL_WMASK[7:0];
        else if (wr_en && frame.addr == istrc_pkg::ADDR_CTRL_HI)
            misc_control_word[15:8] <= frame.data & istrc_pkg::CTRL_WMASK[15:8];
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            external_clock_multiplier <= istrc_pkg::UPSCALE_RESET;
        else if (wr_en && frame.addr == istrc_pkg::ADDR_UPS_LO)
            external_clock_multiplier[7:0] <= frame.data;
        else if (wr_en && frame.addr == istrc_pkg::ADDR_UPS_HI)
            external_clock_multiplier[15:8] <= frame.data;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            output_decimation_rate <= istrc_pkg::DEC_RESET;
        else if (wr_en && frame.addr == istrc_pkg::ADDR_DEC_LO)
            output_decimation_rate[7:0] <= frame.data;
        else if (wr_en && frame.addr == istrc_pkg::ADDR_DEC_HI)
            output_decimation_rate[15:8] <= frame.data;
    end

    always_comb
    begin
        unique case ({rd_addr[6:1], 1'b0})
            istrc_pkg::ADDR_CTRL_LO: read_word = misc_control_word;
            istrc_pkg::ADDR_UPS_LO:  read_word = external_clock_multiplier;
            istrc_pkg::ADDR_DEC_LO:  read_word = output_decimation_rate;
            default:                 read_word = 16'h0000;
        endcase
    end

    // word loaded at frame start, bits leave on falling clock edges
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            tx_shift <= '0;
            DOUT     <= 1'b0;
        end
        else if (cs_fall)
            tx_shift <= read_word;
        else if (ser_state == istrc_pkg::SER_SHIFT && sclk_fall)
        begin
            DOUT     <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample clock sources
    logic [istrc_pkg::TICK_W-1:0]   int_cnt;
    logic                           int_tick;
    logic                           ext_edge;
    logic [istrc_pkg::PERIOD_W-1:0] per_cnt;
    logic [istrc_pkg::PERIOD_W-1:0] period;
    logic [istrc_pkg::ACC_W-1:0]    acc;
    logic [istrc_pkg::ACC_W-1:0]    next_acc;
    logic                           scale_tick;
    logic                           sample_src;

    assign int_tick = (int_cnt == istrc_pkg::TICK_W'(INT_TICK_CYCLES - 1));

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            int_cnt <= '0;
        else if (int_tick)
            int_cnt <= '0;
        else
            int_cnt <= int_cnt + 1'b1;
    end

    assign ext_edge = misc_control_word.sync_rising ? (sync_sync[1] & ~sync_sync[2])
                                                    : (~sync_sync[1] & sync_sync[2]);

    // slow input period measured in system cycles, saturating
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            per_cnt <= '0;
            period  <= '0;
        end
        else if (ext_edge)
        begin
            per_cnt <= '0;
            period  <= per_cnt + 1'b1;
        end
        else if (per_cnt != '1)
            per_cnt <= per_cnt + 1'b1;
    end

    // adding the multiplier each cycle against the period yields exactly
    // multiplier ticks per input period without a divider
    assign next_acc   = acc + istrc_pkg::ACC_W'(external_clock_multiplier);
    assign scale_tick = (period != '0) && (next_acc >= istrc_pkg::ACC_W'(period));

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            acc <= '0;
        else if (misc_control_word.sync_mode != istrc_pkg::SYNC_SCALED || period == '0)
            acc <= '0;
        else if (scale_tick)
            acc <= next_acc - istrc_pkg::ACC_W'(period);
        else
            acc <= next_acc;
    end

    always_comb
    begin
        unique case (misc_control_word.sync_mode)
            istrc_pkg::SYNC_INTERNAL: sample_src = int_tick;
            istrc_pkg::SYNC_DIRECT:   sample_src = ext_edge;
            istrc_pkg::SYNC_SCALED:   sample_src = scale_tick;
            istrc_pkg::SYNC_OUTPUT:   sample_src = int_tick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // decimation
    logic [10:0] dec_eff;
    logic [10:0] dec_cnt;
    logic        update;

    assign dec_eff = (output_decimation_rate[10:0] > istrc_pkg::DEC_MAX) ? istrc_pkg::DEC_MAX
                                                                         : output_decimation_rate[10:0];
    assign update  = sample_src && (dec_cnt >= dec_eff);

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            dec_cnt <= '0;
        else if (update)
            dec_cnt <= '0;
        else if (sample_src)
            dec_cnt <= dec_cnt + 11'h001;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            SAMPLE_TICK   <= 1'b0;
            OUTPUT_UPDATE <= 1'b0;
        end
        else
        begin
            SAMPLE_TICK   <= sample_src;
            OUTPUT_UPDATE <= update;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration outputs
    // burst layout only switches at an update so one array never mixes types
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            BURST_WORD_WIDTH_SELECT <= istrc_pkg::CTRL_RESET[9];
            BURST_DELTA_SELECT      <= istrc_pkg::CTRL_RESET[8];
        end
        else if (update)
        begin
            BURST_WORD_WIDTH_SELECT <= misc_control_word.burst_word_width_select;
            BURST_DELTA_SELECT      <= misc_control_word.burst_delta_select;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            GYRO_LIN_COMP           <= istrc_pkg::CTRL_RESET[7];
            ACCEL_CORNER_ALIGN      <= istrc_pkg::CTRL_RESET[6];
            SENSOR_BANDWIDTH_SELECT <= istrc_pkg::CTRL_RESET[4];
        end
        else
        begin
            GYRO_LIN_COMP           <= misc_control_word.gyro_lin_comp;
            ACCEL_CORNER_ALIGN      <= misc_control_word.accel_corner_align;
            SENSOR_BANDWIDTH_SELECT <= misc_control_word.sensor_bandwidth_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data valid and timing pin outputs
    logic [istrc_pkg::PULSE_W-1:0] dv_cnt;
    logic [istrc_pkg::PULSE_W-1:0] next_dv_cnt;
    logic [istrc_pkg::PULSE_W-1:0] sy_cnt;
    logic [istrc_pkg::PULSE_W-1:0] next_sy_cnt;

    assign next_dv_cnt = update ? istrc_pkg::PULSE_W'(istrc_pkg::DV_PULSE_CYCLES)
                       : (dv_cnt != '0) ? dv_cnt - 1'b1 : dv_cnt;
    assign next_sy_cnt = int_tick ? istrc_pkg::PULSE_W'(istrc_pkg::SYNC_PULSE_CYCLES)
                       : (sy_cnt != '0) ? sy_cnt - 1'b1 : sy_cnt;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            dv_cnt         <= '0;
            DATA_VALID_PIN <= ~istrc_pkg::CTRL_RESET[0];
        end
        else
        begin
            dv_cnt         <= next_dv_cnt;
            DATA_VALID_PIN <= (next_dv_cnt != '0) ^ ~misc_control_word.dv_active_high;
        end
    end

    // pulse sits in the active-edge direction: rising marks low-high-low
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sy_cnt  <= '0;
            SYNC_O  <= 1'b0;
            SYNC_OE <= 1'b0;
        end
        else
        begin
            sy_cnt  <= next_sy_cnt;
            SYNC_OE <= (misc_control_word.sync_mode == istrc_pkg::SYNC_OUTPUT);
            SYNC_O  <= (misc_control_word.sync_mode == istrc_pkg::SYNC_OUTPUT)
                     & ((next_sy_cnt != '0) ^ ~misc_control_word.sync_rising);
        end
    end

endmodule

// ==== testbench/istrc_host_model.sv ====
// host controller model that sends mode 3 serial frames into the block
`timescale 1ns/100ps
module istrc_host_model (
    // clock
    input  wire logic SYS_CLK,
    // serial port
    output logic      SCLK,
    output logic      CS_B,
    output logic      DIN,
    input  wire logic DOUT
);
    initial
    begin
        SCLK = 1'b1;
        CS_B = 1'b1;
        DIN  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // always 16 bits, msb first; slow edges keep sync margin
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge SYS_CLK);
        CS_B = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (5) @(negedge SYS_CLK);
            SCLK = 1'b0;
            DIN  = tx[i];
            repeat (5) @(negedge SYS_CLK);
            rx[i] = DOUT;
            SCLK = 1'b1;
        end
        repeat (5) @(negedge SYS_CLK);
        CS_B = 1'b1;
        // released line must not keep showing the last bit
        DIN  = ~DIN;
        repeat (8) @(negedge SYS_CLK);
    endtask
endmodule

// ==== testbench/istrc_checker.sv ====
// concurrent checks on the ports of the timing and rate control block
`timescale 1ns/100ps
module istrc_checker #(
    parameter int unsigned INT_TICK_CYCLES = 10000
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic SYNC_O,
    input wire logic SYNC_OE,
    input wire logic SAMPLE_TICK,
    input wire logic OUTPUT_UPDATE,
    input wire logic BURST_WORD_WIDTH_SELECT,
    input wire logic BURST_DELTA_SELECT,
    input wire logic GYRO_LIN_COMP,
    input wire logic ACCEL_CORNER_ALIGN,
    input wire logic SENSOR_BANDWIDTH_SELECT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    logic [15:0] gap;
    logic        prev_oe;
    // cycles since last sample; saturates so long gaps stay harmless
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            gap     <= 16'h0000;
            prev_oe <= 1'b0;
        end
        else if (SAMPLE_TICK)
        begin
            gap     <= 16'h0001;
            prev_oe <= SYNC_OE;
        end
        else if (gap != 16'hFFFF)
            gap <= gap + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_upd_on_sample;
        OUTPUT_UPDATE |-> SAMPLE_TICK;
    endproperty
    a_upd_on_sample: assert property (p_upd_on_sample) else $error("update without sample");
    property p_tick_pulse;
        SAMPLE_TICK |=> !SAMPLE_TICK;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("sample tick too long");
    property p_upd_pulse;
        OUTPUT_UPDATE |=> !OUTPUT_UPDATE;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
    property p_out_gap;
        SAMPLE_TICK && SYNC_OE && prev_oe && gap != 16'h0000 |-> gap == 16'(INT_TICK_CYCLES);
    endproperty
    a_out_gap: assert property (p_out_gap) else $error("output sync spacing wrong");
    property p_sync_idle;
        !SYNC_OE && !$past(SYNC_OE) && !$past(SYNC_OE, 2) |-> !SYNC_O;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("timing pin driven value outside output mode");
    property p_burst_at_upd;
        $changed(BURST_WORD_WIDTH_SELECT) || $changed(BURST_DELTA_SELECT) |-> OUTPUT_UPDATE || $past(OUTPUT_UPDATE);
    endproperty
    a_burst_at_upd: assert property (p_burst_at_upd) else $error("burst select moved off update");
    property p_opt_after_frame;
        $changed(GYRO_LIN_COMP) || $changed(ACCEL_CORNER_ALIGN) || $changed(SENSOR_BANDWIDTH_SELECT)
            |-> CS_B && $past(CS_B, 4);
    endproperty
    a_opt_after_frame: assert property (p_opt_after_frame) else $error("option moved without frame");
    property p_oe_after_frame;
        $changed(SYNC_OE) |-> CS_B && $past(CS_B, 4);
    endproperty
    a_oe_after_frame: assert property (p_oe_after_frame) else $error("pin direction moved without frame");
endmodule
bind istrc_top istrc_checker #(.INT_TICK_CYCLES(INT_TICK_CYCLES)) u_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .CS_B(CS_B), .SYNC_O(SYNC_O), .SYNC_OE(SYNC_OE),
    .SAMPLE_TICK(SAMPLE_TICK), .OUTPUT_UPDATE(OUTPUT_UPDATE),
    .BURST_WORD_WIDTH_SELECT(BURST_WORD_WIDTH_SELECT), .BURST_DELTA_SELECT(BURST_DELTA_SELECT),
    .GYRO_LIN_COMP(GYRO_LIN_COMP), .ACCEL_CORNER_ALIGN(ACCEL_CORNER_ALIGN),
    .SENSOR_BANDWIDTH_SELECT(SENSOR_BANDWIDTH_SELECT));

// ==== testbench/istrc_tb_top.sv ====
// self-checking testbench of the timing and rate control block
`timescale 1ns/100ps
module istrc_tb_top;
    localparam int unsigned TICK = 40;
    logic        SYS_CLK, RST_B, SYNC_I;
    logic        SCLK, CS_B, DIN, DOUT, SYNC_O, SYNC_OE, DATA_VALID_PIN, SAMPLE_TICK, OUTPUT_UPDATE;
    logic        BURST_WORD_WIDTH_SELECT, BURST_DELTA_SELECT, GYRO_LIN_COMP, ACCEL_CORNER_ALIGN;
    logic        SENSOR_BANDWIDTH_SELECT;
    logic [15:0] rx;
    logic [7:0]  v;
    int          miscompares, checks, n;
    istrc_host_model host (.SYS_CLK(SYS_CLK), .SCLK(SCLK), .CS_B(CS_B), .DIN(DIN), .DOUT(DOUT));
    istrc_top #(.INT_TICK_CYCLES(TICK)) uut (
        .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .DIN(DIN), .DOUT(DOUT),
        .SYNC_I(SYNC_I), .SYNC_O(SYNC_O), .SYNC_OE(SYNC_OE), .DATA_VALID_PIN(DATA_VALID_PIN),
        .SAMPLE_TICK(SAMPLE_TICK), .OUTPUT_UPDATE(OUTPUT_UPDATE),
        .BURST_WORD_WIDTH_SELECT(BURST_WORD_WIDTH_SELECT), .BURST_DELTA_SELECT(BURST_DELTA_SELECT),
        .GYRO_LIN_COMP(GYRO_LIN_COMP), .ACCEL_CORNER_ALIGN(ACCEL_CORNER_ALIGN),
        .SENSOR_BANDWIDTH_SELECT(SENSOR_BANDWIDTH_SELECT));
    initial
    begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b1, a, d}, rx);
    endtask
    // answer comes in the frame after the request
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        host.xfer({1'b0, a, 8'h00}, rx);
        host.xfer(16'h0000, rx);
        chk(rx, exp);
    endtask
    task automatic wait_upd;
        n = 0;
        do
        begin
            @(negedge SYS_CLK);
            n++;
        end while (OUTPUT_UPDATE !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic count_ticks(input int cyc);
        repeat (cyc)
        begin
            @(negedge SYS_CLK);
            if (SAMPLE_TICK === 1'b1)
                n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        RST_B = 1'b0;
        SYNC_I = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (20) @(negedge SYS_CLK);
        RST_B = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        chk(16'({GYRO_LIN_COMP, ACCEL_CORNER_ALIGN, SENSOR_BANDWIDTH_SELECT, SYNC_OE}), 16'h000C);
        rd(7'h60, 16'h00C1);
        rd(7'h62, 16'h07D0);
        rd(7'h64, 16'h0000);
        rd(7'h66, 16'h0000);
        wait_upd();
        wait_upd();
        chk(16'(n), 16'(TICK));
        wr(7'h60, 8'h81);
        wr(7'h61, 8'h00);
        rd(7'h60, 16'h0081);
        chk(16'({GYRO_LIN_COMP, ACCEL_CORNER_ALIGN}), 16'h0002);
        wr(7'h60, 8'h41);
        wr(7'h6F, 8'h00);
        rd(7'h60, 16'h0041);
        chk(16'({GYRO_LIN_COMP, ACCEL_CORNER_ALIGN}), 16'h0001);
        // spare bit set on purpose: must read back as zero
        wr(7'h60, 8'h31);
        rd(7'h60, 16'h0011);
        chk(16'(SENSOR_BANDWIDTH_SELECT), 16'h0001);
        wr(7'h61, 8'h03);
        wait_upd();
        wait_upd();
        chk(16'({BURST_WORD_WIDTH_SELECT, BURST_DELTA_SELECT}), 16'h0003);
        wr(7'h64, 8'h03);
        wr(7'h65, 8'h08);
        rd(7'h64, 16'h0803);
        wait_upd();
        wait_upd();
        chk(16'(n), 16'(4 * TICK));
        for (int p = 1; p >= 0; p--)
        begin
            wr(7'h60, 8'h04 | 8'(p << 1));
            for (int k = 0; k < 3; k++)
            begin
                n = 0;
                SYNC_I = 1'b1;
                count_ticks(12);
                chk(16'(n), 16'(p));
                n = 0;
                SYNC_I = 1'b0;
                count_ticks(12);
                chk(16'(n), 16'(1 - p));
            end
        end
        wr(7'h64, 8'h00);
        wr(7'h65, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            v = k ? 8'h0E : 8'h0D;
            wr(7'h60, v);
            wait_upd();
            wait_upd();
            chk(16'({SYNC_OE, DATA_VALID_PIN}), 16'({1'b1, v[0]}));
            repeat (2) @(negedge SYS_CLK);
            chk(16'(SYNC_O), 16'(v[1]));
            repeat (28) @(negedge SYS_CLK);
            chk(16'({SYNC_O, DATA_VALID_PIN}), 16'({~v[1], ~v[0]}));
        end
        // scaled mode: 4 samples per 400-cycle input period
        wr(7'h62, 8'h04);
        wr(7'h63, 8'h00);
        wr(7'h60, 8'h0B);
        n = 0;
        for (int p = 0; p < 5; p++)
        begin
            if (p == 2)
                n = 0;
            SYNC_I = 1'b1;
            count_ticks(200);
            SYNC_I = 1'b0;
            count_ticks(200);
        end
        chk(16'(n), 16'h000C);
        end_of_test();
    end
endmodule
